// File: dv/iep_core_model.sv
// behavioural core that takes and returns offered interrupts
module iep_core_model (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // request port
    input  wire logic       coreReq,
    input  wire logic [2:0] coreSrc,
    input  wire logic [1:0] coreLevel,
    output logic            coreAck,
    output logic            coreReti,
    // bench control and log
    input  wire logic [3:0] ackDelay,
    input  wire logic       retiReq,
    output logic      [7:0] ackCount,
    output logic      [2:0] lastSrc,
    output logic      [1:0] lastLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] waitCnt;
    logic [2:0] depth;
    logic       taken;
    assign taken = coreAck && coreReq;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            {coreAck, coreReti, waitCnt, depth, ackCount, lastSrc, lastLevel} <= '0;
        end else begin
            coreAck  <= coreReq && !coreAck && waitCnt >= ackDelay;
            waitCnt  <= (coreReq && !coreAck) ? waitCnt + 4'h1 : 4'h0;
            coreReti <= retiReq && depth != 3'h0;
            depth    <= depth + 3'(taken) - 3'(coreReti);
            if (taken) begin
                ackCount  <= ackCount + 8'h01;
                lastSrc   <= coreSrc;
                lastLevel <= coreLevel;
            end
        end
    end
endmodule : iep_core_model

// File: dv/iep_irq_ctrl_assertions.sv
// checker for the interrupt enable and priority block ports
module iep_irq_ctrl_chk (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // core port and interrupt
    input wire logic        coreReq,
    input wire logic [2:0]  coreSrc,
    input wire logic        coreAck,
    input wire logic        irqOut
);
    timeunit 1ns;
    timeprecision 1ps;
    logic gen;
    logic maskNz;
    // shadows follow whole-byte writes only; bit ops on bit 7 are not tracked
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gen    <= 1'b0;
            maskNz <= 1'b0;
        end else if (psel && penable && pwrite && pstrb[0]) begin
            if (paddr == 12'h2A0) gen <= pwdata[7];
            if (paddr == 12'h304) maskNz <= |pwdata[4:0];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_ready_always: assert property (pready) else $error("pready low");
    a_err_phase: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
    a_err_misalign: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access not refused");
    a_rdata_hold: assert property (!psel |=> $stable(prdata)) else $error("prdata moved while idle");
    a_ack_drops: assert property (coreReq && coreAck |=> !coreReq) else $error("request kept after ack");
    a_src_range: assert property (coreReq |-> coreSrc <= 3'h4) else $error("source out of range");
    a_global_gate: assert property (!gen && !$past(gen) |-> !coreReq)
        else $error("request with global enable clear");
    a_mask_gate: assert property (!maskNz && !$past(maskNz) |-> !irqOut) else $error("irq with mask clear");
endmodule : iep_irq_ctrl_chk
bind iep_irq_ctrl iep_irq_ctrl_chk u_chk (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pstrb   (pstrb),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .coreReq (coreReq),
    .coreSrc (coreSrc),
    .coreAck (coreAck),
    .irqOut  (irqOut)
);

// File: dv/testbench.sv
// bench: register access, gating, priority and interrupt status
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_EN = 12'h2A0, A_HI = 12'h2DC, A_LO = 12'h2E0;
    localparam logic [11:0] A_ST = 12'h300, A_MK = 12'h304, A_BO = 12'h308, A_SV = 12'h30C;
    logic        mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, retiReq = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [4:0]  srcEvent = '0, hi = '0, lo = '0;
    logic [3:0]  ackDelay = '0;
    logic [2:0]  coreSrc, lastSrc;
    logic [1:0]  coreLevel, lastLevel;
    logic [7:0]  ackCount;
    logic        pready, pslverr, coreReq, coreAck, coreReti, irqOut, err;
    int          failures = 0, num_checks = 0, cyc = 0;
    always #20 mclk = ~mclk;
    iep_irq_ctrl uut (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .pstrb     (4'hF),
        .prdata    (prdata),
        .pready    (pready),
        .pslverr   (pslverr),
        .srcEvent  (srcEvent),
        .coreReq   (coreReq),
        .coreSrc   (coreSrc),
        .coreLevel (coreLevel),
        .coreAck   (coreAck),
        .coreReti  (coreReti),
        .irqOut    (irqOut)
    );
    iep_core_model model (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .coreReq   (coreReq),
        .coreSrc   (coreSrc),
        .coreLevel (coreLevel),
        .coreAck   (coreAck),
        .coreReti  (coreReti),
        .ackDelay  (ackDelay),
        .retiReq   (retiReq),
        .ackCount  (ackCount),
        .lastSrc   (lastSrc),
        .lastLevel (lastLevel)
    );
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, '0);
        chk(n, e, rd);
    endtask : rdc
    // irq output may be registered, so allow two edges
    task automatic irqc(input logic e);
        repeat (2) @(posedge mclk);
        chk("irq", e, irqOut);
    endtask : irqc
    // fixed window: a missing ack must stay missing for the whole span
    task automatic step(input logic [4:0] ev, input logic rt, input int s);
        logic [7:0] n0;
        n0 = ackCount;
        @(posedge mclk);
        srcEvent <= ev;
        retiReq <= rt;
        @(posedge mclk);
        srcEvent <= '0;
        retiReq <= 1'b0;
        repeat (16) @(posedge mclk);
        chk("acks", n0 + 8'(s >= 0), ackCount);
        if (s >= 0) begin
            chk("src", s, lastSrc);
            chk("level", {hi[s], lo[s]}, lastLevel);
        end
    endtask : step
    task automatic finish_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 4000) begin
            failures++;
            finish_test();
        end
    end
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rdc("enable", A_EN, '0);
        rdc("high", A_HI, '0);
        rdc("low", A_LO, '0);
        apb(1'b1, A_BO, 32'h0B);
        rdc("enable", A_EN, 32'h08);
        apb(1'b1, A_BO, 32'h1B);
        rdc("low", A_LO, 32'h08);
        apb(1'b1, A_BO, 32'h2B);
        chk("refused", 1, err);
        rdc("high", A_HI, '0);
        apb(1'b1, A_EN, 32'h9F);
        rdc("enable", A_EN, 32'h9F);
        apb(1'b0, 12'h000, '0);
        chk("unmapped", 1, err);
        chk("unmapped data", 0, rd);
        apb(1'b1, 12'h2A2, '0);
        chk("misaligned", 1, err);
        $display("test registers done");
        apb(1'b1, A_LO, '0);
        apb(1'b1, A_EN, 32'h1F);
        step(5'h1F, 1'b0, -1);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, A_EN, 32'h80 | (32'h1 << i));
            step('0, 1'b0, i);
            apb(1'b1, A_EN, 32'h80);
            step('0, 1'b1, -1);
        end
        $display("test gating done");
        hi = 5'h02;
        lo = 5'h11;
        apb(1'b1, A_HI, 32'(hi));
        apb(1'b1, A_LO, 32'(lo));
        rdc("high", A_HI, 32'(hi));
        rdc("low", A_LO, 32'(lo));
        apb(1'b1, A_EN, 32'h9F);
        ackDelay <= 4'h3;
        step(5'h1F, 1'b0, 1);
        step('0, 1'b1, 0);
        step('0, 1'b1, 4);
        step('0, 1'b1, 2);
        step(5'h02, 1'b0, 1);
        // levels 2 and 0 in service, timer 1 waiting at level 0 and held back
        rdc("service", A_SV, 32'h0C5);
        step('0, 1'b1, -1);
        step('0, 1'b1, 3);
        step('0, 1'b1, -1);
        $display("test priority done");
        apb(1'b1, A_EN, '0);
        step(5'h04, 1'b0, -1);
        rdc("status", A_ST, 32'h04);
        irqc(1'b0);
        apb(1'b1, A_MK, 32'h04);
        rdc("mask", A_MK, 32'h04);
        irqc(1'b1);
        apb(1'b1, A_ST, 32'h04);
        rdc("status", A_ST, '0);
        irqc(1'b0);
        $display("test interrupt done");
        finish_test();
    end
endmodule : testbench

// File: hdl/iep_irq_ctrl.sv
// interrupt enable and priority registers with APB access and core request port
module iep_irq_ctrl (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // source events
    input  wire logic [4:0]  srcEvent,
    // core request port
    output logic             coreReq,
    output logic      [2:0]  coreSrc,
    output logic      [1:0]  coreLevel,
    input  wire logic        coreAck,
    input  wire logic        coreReti,
    // software interrupt
    output logic             irqOut
);
    localparam int NSRC = iep_pkg::NUM_SRC;

    typedef struct packed {
        logic            globalEn;
        logic [NSRC-1:0] srcEn;
        logic [NSRC-1:0] prioHigh;
        logic [NSRC-1:0] prioLow;
        logic [NSRC-1:0] pending;
        logic [NSRC-1:0] mask;
        logic [3:0]      inService;
        logic [31:0]     rdata;
        logic            err;
        logic            reqValid;
        logic [2:0]      reqSrc;
        logic [1:0]      reqLevel;
    } iep_state_s;

    localparam iep_state_s STATE_RESET = '{
        globalEn:  iep_pkg::GLOBAL_EN_RESET,
        srcEn:     iep_pkg::ENABLE_RESET,
        prioHigh:  iep_pkg::PRIO_RESET,
        prioLow:   iep_pkg::PRIO_RESET,
        pending:   5'h00,
        mask:      iep_pkg::MASK_RESET,
        inService: 4'h0,
        rdata:     32'h0000_0000,
        err:       1'b0,
        reqValid:  1'b0,
        reqSrc:    3'b000,
        reqLevel:  2'b00
    };

    iep_state_s      s;
    iep_state_s      next_s;
    logic            rstSync_n;
    logic [NSRC-1:0] arbReq;
    logic            arbValid;
    logic [2:0]      arbSrc;
    logic [1:0]      arbLevel;

    // word-aligned hit on a register index
    function automatic logic isReg(input logic [11:0] addr, input logic [7:0] idx);
        isReg = (addr[1:0] == 2'b00) && (addr[11:10] == 2'b00) && (addr[9:2] == idx);
    endfunction : isReg

    // highest level now in service
    function automatic logic [1:0] topLevel(input logic [3:0] svc);
        topLevel = 2'b00;
        for (int l = 0; l < 4; l++) begin
            if (svc[l]) begin
                topLevel = 2'(l);
            end
        end
    endfunction : topLevel

    iep_rst_sync u_rst_sync (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .rstSync_n (rstSync_n)
    );

    // global gate; own enable decides; pending and both enables
    assign arbReq = s.pending & s.srcEn & {NSRC{s.globalEn}};

    iep_prio_arbiter #(
        .NSRC (NSRC)
    ) u_arbiter (
        .req      (arbReq),
        .prioHigh (s.prioHigh),
        .prioLow  (s.prioLow),
        .valid    (arbValid),
        .src      (arbSrc),
        .level    (arbLevel)
    );

    always_comb begin
        logic            setup;
        logic            wrAcc;
        logic            acked;
        logic            active;
        logic [1:0]      curLevel;
        logic [NSRC-1:0] clr;
        logic [2:0]      bitPos;
        logic            bitVal;
        logic [1:0]      tgt;
        next_s   = s;
        setup    = psel && !penable;
        wrAcc    = psel && penable && pwrite && !s.err && pstrb[0];
        acked    = coreAck && s.reqValid;
        active   = |s.inService;
        curLevel = topLevel(s.inService);
        clr      = '0;
        bitPos   = pwdata[2:0];
        bitVal   = pwdata[iep_pkg::BIT_OP_VALUE];
        tgt      = pwdata[iep_pkg::BIT_OP_TGT_LO +: 2];

        // read data and error decided in the setup cycle
        if (setup) begin
            next_s.rdata = 32'h0000_0000;
            next_s.err   = 1'b0;
            if (isReg(paddr, iep_pkg::IDX_ENABLE)) begin
                next_s.rdata[7:0] = {s.globalEn, 2'b00, s.srcEn};
            end else if (isReg(paddr, iep_pkg::IDX_PRIO_HIGH)) begin
                next_s.rdata[7:0] = {3'b000, s.prioHigh};
            end else if (isReg(paddr, iep_pkg::IDX_PRIO_LOW)) begin
                next_s.rdata[7:0] = {3'b000, s.prioLow};
            end else if (isReg(paddr, iep_pkg::IDX_STATUS)) begin
                next_s.rdata[7:0] = {3'b000, s.pending};
            end else if (isReg(paddr, iep_pkg::IDX_MASK)) begin
                next_s.rdata[7:0] = {3'b000, s.mask};
            end else if (isReg(paddr, iep_pkg::IDX_BIT_OP)) begin
                // high priority register refuses bit access
                next_s.err = pwrite && (tgt == iep_pkg::IEP_TGT_HIGH);
            end else if (isReg(paddr, iep_pkg::IDX_SERVICE)) begin
                next_s.rdata[11:0] = {s.reqValid, s.reqLevel, s.reqSrc, 2'b00, s.inService};
            end else begin
                next_s.err = 1'b1;
            end
        end

        // register writes land at the access edge
        if (wrAcc) begin
            if (isReg(paddr, iep_pkg::IDX_ENABLE)) begin
                next_s.globalEn = pwdata[iep_pkg::GLOBAL_EN_BIT];
                next_s.srcEn    = pwdata[NSRC-1:0];
            end else if (isReg(paddr, iep_pkg::IDX_PRIO_HIGH)) begin
                next_s.prioHigh = pwdata[NSRC-1:0];
            end else if (isReg(paddr, iep_pkg::IDX_PRIO_LOW)) begin
                next_s.prioLow = pwdata[NSRC-1:0];
            end else if (isReg(paddr, iep_pkg::IDX_STATUS)) begin
                clr = pwdata[NSRC-1:0];
            end else if (isReg(paddr, iep_pkg::IDX_MASK)) begin
                next_s.mask = pwdata[NSRC-1:0];
            end else if (isReg(paddr, iep_pkg::IDX_BIT_OP)) begin
                if (tgt == iep_pkg::IEP_TGT_ENABLE) begin
                    if (bitPos == 3'(iep_pkg::GLOBAL_EN_BIT)) begin
                        next_s.globalEn = bitVal;
                    end else if (bitPos < 3'(NSRC)) begin
                        next_s.srcEn[bitPos] = bitVal;
                    end
                // single-bit access to low priority register
                end else if (tgt == iep_pkg::IEP_TGT_LOW) begin
                    if (bitPos < 3'(NSRC)) begin
                        next_s.prioLow[bitPos] = bitVal;
                    end
                end
            end
        end

        // return from service drops the top level first
        if (coreReti && active) begin
            next_s.inService[curLevel] = 1'b0;
        end
        if (acked) begin
            clr[s.reqSrc]                = 1'b1;
            next_s.inService[s.reqLevel] = 1'b1;
        end

        // a new event wins over any clear in the same cycle
        next_s.pending = (s.pending & ~clr) | srcEvent;

        // only strictly higher level preempts; nothing exceeds 3
        next_s.reqValid = arbValid && (!active || arbLevel > curLevel) && !acked && !coreReti;
        next_s.reqSrc   = arbSrc;
        next_s.reqLevel = arbLevel;
    end

    always_ff @(posedge mclk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            s <= STATE_RESET;
        end else begin
            s <= next_s;
        end
    end

    // zero wait state; read data was captured in setup
    assign pready    = 1'b1;
    assign prdata    = s.rdata;
    assign pslverr   = psel && penable && s.err;
    assign coreReq   = s.reqValid;
    assign coreSrc   = s.reqSrc;
    assign coreLevel = s.reqLevel;
    assign irqOut    = |(s.pending & s.mask);
endmodule : iep_irq_ctrl

// File: hdl/iep_pkg.sv
// constants for the interrupt enable and priority register block
// Function
// - global enable low blocks every source regardless of own enables
// - global enable high lets each source follow its own enable bit
// - enable bit 4 gates the serial port request
// - enable bit 3 gates the timer 1 overflow request
// - enable bit 2 gates external interrupt 1
// - enable bit 1 gates the timer 0 overflow request
// - enable bit 0 gates external interrupt 0
// - enable register at index A8h, global bit 7, sources bits 4..0
// - low priority register at index B8h, sources in bits 4..0
// - high priority register at index B7h, same source order
// - enable register resets to zero and allows single-bit writes
// - low priority register resets to zero and allows single-bit writes
// - high priority register resets to zero, whole byte access only
// - reserved bits read any value; software writes no ones there
// - level is high bit over low bit, 0 lowest to 3 highest
// - only a strictly higher level preempts; level 3 never preempted
// - among simultaneous requests the highest level wins
// - equal levels resolved by fixed polling order
package iep_pkg;
    localparam int NUM_SRC = 5;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_ENABLE    = 8'hA8;
    localparam logic [7:0] IDX_PRIO_HIGH = 8'hB7;
    localparam logic [7:0] IDX_PRIO_LOW  = 8'hB8;
    localparam logic [7:0] IDX_STATUS    = 8'hC0;
    localparam logic [7:0] IDX_MASK      = 8'hC1;
    localparam logic [7:0] IDX_BIT_OP    = 8'hC2;
    localparam logic [7:0] IDX_SERVICE   = 8'hC3;
    // field positions
    localparam int GLOBAL_EN_BIT = 7;
    localparam int BIT_OP_VALUE  = 3;
    localparam int BIT_OP_TGT_LO = 4;
    // reset values
    localparam logic [4:0] ENABLE_RESET    = 5'h00;
    localparam logic       GLOBAL_EN_RESET = 1'b0;
    localparam logic [4:0] PRIO_RESET      = 5'h00;
    localparam logic [4:0] MASK_RESET      = 5'h00;
    // source numbers; lower number polled first within a level
    typedef enum logic [2:0] {
        IEP_SRC_EXT0   = 3'b000,
        IEP_SRC_TIMER0 = 3'b001,
        IEP_SRC_EXT1   = 3'b010,
        IEP_SRC_TIMER1 = 3'b011,
        IEP_SRC_SERIAL = 3'b100
    } iep_src_e;
    // single-bit operation targets
    typedef enum logic [1:0] {
        IEP_TGT_ENABLE = 2'b00,
        IEP_TGT_LOW    = 2'b01,
        IEP_TGT_HIGH   = 2'b10,
        IEP_TGT_NONE   = 2'b11
    } iep_tgt_e;
endpackage : iep_pkg

// File: hdl/iep_prio_arbiter.sv
// level formation and winner selection among enabled requests
module iep_prio_arbiter #(
    parameter int NSRC = iep_pkg::NUM_SRC
) (
    // requests and priority bits
    input  wire logic [NSRC-1:0] req,
    input  wire logic [NSRC-1:0] prioHigh,
    input  wire logic [NSRC-1:0] prioLow,
    // winner
    output logic                 valid,
    output logic [2:0]           src,
    output logic [1:0]           level
);
    always_comb begin
        valid = 1'b0;
        src   = 3'b000;
        level = 2'b00;
        // highest level wins; walk down so lower number wins a tie
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req[i] && (!valid || {prioHigh[i], prioLow[i]} >= level)) begin
                valid = 1'b1;
                src   = 3'(i);
                level = {prioHigh[i], prioLow[i]};
            end
        end
    end
endmodule : iep_prio_arbiter

// File: hdl/iep_rst_sync.sv
// reset release synchroniser
module iep_rst_sync (
    // clock and raw reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // synchronised reset
    output logic      rstSync_n
);
    logic [1:0] stage;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stage <= 2'b00;
        end else begin
            stage <= {stage[0], 1'b1};
        end
    end

    assign rstSync_n = stage[1];
endmodule : iep_rst_sync
